// [verilog/i2cm_params.svh]
`ifndef I2CM_PARAMS_SVH
`define I2CM_PARAMS_SVH

// Clock and bit timing
`define I2CM_CLK_PERIOD_NS 5
`define I2CM_QTR_NS        2500
`define I2CM_QTR_CYC       ((`I2CM_QTR_NS) / (`I2CM_CLK_PERIOD_NS))

// Control flag bit positions
`define I2CM_EN_BIT  6
`define I2CM_STA_BIT 5
`define I2CM_STO_BIT 4
`define I2CM_SI_BIT  3
`define I2CM_AA_BIT  2

// Reset values
`define I2CM_FLAGS_RST 8'h00
`define I2CM_CODE_RST  8'hF8
`define I2CM_MASK_RST  8'hFF

// Status codes, low three bits always zero
`define I2CM_ST_START   8'h08
`define I2CM_ST_RESTART 8'h10
`define I2CM_ST_AW_ACK  8'h18
`define I2CM_ST_AW_NACK 8'h20
`define I2CM_ST_D_ACK   8'h28
`define I2CM_ST_D_NACK  8'h30
`define I2CM_ST_LOST    8'h38
`define I2CM_ST_AR_ACK  8'h40
`define I2CM_ST_AR_NACK 8'h48

`endif

// [verilog/i2cm_pkg.sv]
`default_nettype none

package i2cm_pkg;

    // Bus line levels carried together
    typedef struct packed {
        logic scl;
        logic sda;
    } i2cm_pins_t;

    // Sequencer states, Gray along idle-wait-start-byte-hold-stop-restart
    typedef enum logic [2:0] {
        I2CM_IDLE      = 3'h0,
        I2CM_WAIT_FREE = 3'h1,
        I2CM_START     = 3'h3,
        I2CM_BYTE      = 3'h2,
        I2CM_HOLD      = 3'h6,
        I2CM_STOP      = 3'h7,
        I2CM_RESTART   = 3'h5
    } i2cm_state_t;

endpackage

`default_nettype wire

// [verilog/i2cm_pin_sync.sv]
`timescale 1ns/1ps
`default_nettype none

module i2cm_pin_sync
    import i2cm_pkg::*;
(
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       reset_n,
    // Raw and filtered levels
    input  wire i2cm_pins_t pins_raw,
    output var  i2cm_pins_t pins_clean
);

    logic [1:0] ff1_reg;
    logic [1:0] ff2_reg;
    logic [1:0] ff3_reg;
    logic [1:0] clean_reg;
    logic [1:0] clean_next;

    ////////////////////////////////////////////////////////////////////////////
    // Per line: a change counts once stages two and three agree
    for (genvar i = 0; i < 2; i++) begin : g_line
        always_comb begin
            clean_next[i] = (ff2_reg[i] == ff3_reg[i]) ? ff3_reg[i] : clean_reg[i];
        end
    end

    // Lines idle high, so reset to high
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            ff1_reg   <= 2'h3;
            ff2_reg   <= 2'h3;
            ff3_reg   <= 2'h3;
            clean_reg <= 2'h3;
        end else begin
            ff1_reg   <= pins_raw;
            ff2_reg   <= ff1_reg;
            ff3_reg   <= ff2_reg;
            clean_reg <= clean_next;
        end
    end

    assign pins_clean = clean_reg;

endmodule // i2cm_pin_sync

`default_nettype wire

// [verilog/i2cm_master_tx.sv]
// Operation
// - Start only once bus seen free.
// - After START raise flag, code 0x08.
// - Transfer suspended while flag set.
// - Flag cleared at 0x08 sends address byte.
// - Write address sent: flag set, 0x18/0x20/0x38.
// - No slave codes, even with acknowledge enabled.
// - 0x18 address acked, 0x20 not acked.
// - Data byte: 0x28 acked, 0x30 not.
// - Plain clear sends next byte, even after NACK.
// - Begin request alone gives repeated START.
// - Halt request alone gives STOP, auto-cleared.
// - Both requests: STOP then START, halt cleared.
// - Address+read after 0x10 enters receive mode.
// - Address+write after 0x10 repeats write phase.
// - Lost, no begin request: release bus.
// - Lost with begin request: START when free.
// - Set port sets, clear port clears flags.
// - Code in top five bits, low zero.
// - SCL held low while flag set.
`timescale 1ns/1ps
`default_nettype none
`include "i2cm_params.svh"

module i2cm_master_tx
    import i2cm_pkg::*;
#(
    parameter int unsigned QTR_CYC = `I2CM_QTR_CYC
) (
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       reset_n,
    // Control flag ports
    input  wire logic       flag_set_write,
    input  wire logic [7:0] flag_set_port,
    input  wire logic       flag_clear_write,
    input  wire logic [7:0] flag_clear_port,
    output logic      [7:0] operation_flags,
    // Data and status
    input  wire logic       data_write,
    input  wire logic [7:0] data_in,
    output logic      [7:0] shift_byte_register,
    output logic      [7:0] bus_condition_code,
    output logic            master_receive_mode,
    // Bus lines, enable high while driving low
    input  wire logic       scl_in,
    output logic            scl_out,
    output logic            scl_oe,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe
);

    localparam logic [15:0] QTR_LAST = 16'(QTR_CYC - 1);

    i2cm_pins_t  pins;
    i2cm_pins_t  pins_raw;
    i2cm_state_t state_reg,  state_next;
    logic [1:0]  phase_reg,  phase_next;
    logic [3:0]  bit_reg,    bit_next;
    logic [8:0]  tx_reg,     tx_next;
    logic [7:0]  flags_reg,  flags_next;
    logic [7:0]  code_reg,   code_next;
    logic [7:0]  data_reg,   data_next;
    logic [15:0] div_reg,    div_next;
    i2cm_pins_t  prev_reg,   prev_next;
    logic        busy_reg,   busy_next;
    logic        addr_reg,   addr_next;
    logic        lost_reg,   lost_next;
    logic        rstrt_reg,  rstrt_next;
    logic        mrx_reg,    mrx_next;
    logic        scl_oe_reg, scl_oe_next;
    logic        sda_oe_reg, sda_oe_next;
    logic        tick;
    logic        si_set;
    logic        sto_clr;
    logic [7:0]  si_code;
    logic        sda_now;

    ////////////////////////////////////////////////////////////////////////////
    // Pin sampling
    assign pins_raw.scl = scl_in;
    assign pins_raw.sda = sda_in;

    i2cm_pin_sync u_sync (
        .ref_clk    (ref_clk),
        .reset_n    (reset_n),
        .pins_raw   (pins_raw),
        .pins_clean (pins)
    );

    assign tick = (div_reg == 16'h0000);

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic for the whole sequencer
    always_comb begin
        state_next  = state_reg;
        phase_next  = phase_reg;
        bit_next    = bit_reg;
        tx_next     = tx_reg;
        code_next   = code_reg;
        div_next    = tick ? QTR_LAST : div_reg - 16'h0001;
        addr_next   = addr_reg;
        lost_next   = lost_reg;
        rstrt_next  = rstrt_reg;
        mrx_next    = mrx_reg;
        scl_oe_next = scl_oe_reg;
        sda_oe_next = sda_oe_reg;
        si_set      = 1'b0;
        sto_clr     = 1'b0;
        si_code     = code_reg;
        sda_now     = 1'b1;
        prev_next   = pins;

        // Bus busy between any START and STOP seen on the lines
        busy_next = busy_reg;
        if (prev_reg.scl && pins.scl && prev_reg.sda && !pins.sda) begin
            busy_next = 1'b1;
        end else if (prev_reg.scl && pins.scl && !prev_reg.sda && pins.sda) begin
            busy_next = 1'b0;
        end

        // Software writes to the data byte
        data_next = data_write ? data_in : data_reg;

        case (state_reg)
            I2CM_IDLE: begin
                scl_oe_next = 1'b0;
                sda_oe_next = 1'b0;
                if (flags_reg[`I2CM_STA_BIT] && !flags_reg[`I2CM_SI_BIT]) begin
                    state_next = I2CM_WAIT_FREE;
                    rstrt_next = 1'b0;
                end
            end
            I2CM_WAIT_FREE: begin
                // Free means no START seen since the last STOP, lines high
                if (tick && !busy_reg && pins.scl && pins.sda) begin
                    state_next  = I2CM_START;
                    phase_next  = 2'h0;
                    sda_oe_next = 1'b1;
                end
            end
            I2CM_START: begin
                if (tick) begin
                    phase_next = phase_reg + 2'h1;
                    if (phase_reg == 2'h1) begin
                        scl_oe_next = 1'b1;
                        si_set      = 1'b1;
                        si_code     = rstrt_reg ? `I2CM_ST_RESTART : `I2CM_ST_START;
                        rstrt_next  = 1'b0;
                        mrx_next    = 1'b0;
                        state_next  = I2CM_HOLD;
                    end
                end
            end
            I2CM_HOLD: begin
                // Clock stretched until software drops the flag
                scl_oe_next = 1'b1;
                if (!flags_reg[`I2CM_SI_BIT]) begin
                    phase_next = 2'h0;
                    if (code_reg == `I2CM_ST_LOST) begin
                        // Arbitration lost: release, or retry when free
                        scl_oe_next = 1'b0;
                        sda_oe_next = 1'b0;
                        lost_next   = 1'b0;
                        state_next  = flags_reg[`I2CM_STA_BIT] ? I2CM_WAIT_FREE
                                                                : I2CM_IDLE;
                    end else if (code_reg == `I2CM_ST_START ||
                                 code_reg == `I2CM_ST_RESTART) begin
                        // Address byte, direction in bit 0
                        tx_next    = {data_reg, 1'b1};
                        bit_next   = 4'h0;
                        addr_next  = 1'b1;
                        state_next = I2CM_BYTE;
                    end else if (flags_reg[`I2CM_STO_BIT]) begin
                        state_next = I2CM_STOP;
                    end else if (flags_reg[`I2CM_STA_BIT]) begin
                        state_next = I2CM_RESTART;
                    end else begin
                        // Next data byte, whatever the last acknowledge was
                        tx_next    = {data_reg, 1'b1};
                        bit_next   = 4'h0;
                        addr_next  = 1'b0;
                        state_next = I2CM_BYTE;
                    end
                end
            end
            I2CM_BYTE: begin
                if (phase_reg == 2'h2) begin
                    // Wait out a slave that stretches the clock
                    if (pins.scl) begin
                        phase_next = 2'h3;
                    end
                end else if (tick) begin
                    phase_next = phase_reg + 2'h1;
                    if (phase_reg == 2'h0) begin
                        sda_oe_next = !tx_reg[8] && !lost_reg;
                    end else if (phase_reg == 2'h1) begin
                        scl_oe_next = 1'b0;
                    end else begin
                        sda_now     = pins.sda;
                        scl_oe_next = 1'b1;
                        tx_next     = {tx_reg[7:0], 1'b1};
                        bit_next    = bit_reg + 4'h1;
                        // A low line while we release it means another master won
                        if (bit_reg != 4'h8 && !sda_oe_reg && !sda_now) begin
                            lost_next   = 1'b1;
                            sda_oe_next = 1'b0;
                        end
                        if (bit_reg == 4'h8) begin
                            sda_oe_next = 1'b0;
                            si_set      = 1'b1;
                            state_next  = I2CM_HOLD;
                            // Only the master-side lost code; no own-address match
                            if (lost_reg) begin
                                si_code = `I2CM_ST_LOST;
                            end else if (addr_reg && data_reg[0]) begin // Read bit of address
                                si_code  = !sda_now ? `I2CM_ST_AR_ACK
                                                    : `I2CM_ST_AR_NACK;
                                mrx_next = 1'b1;
                            end else if (addr_reg) begin
                                si_code = !sda_now ? `I2CM_ST_AW_ACK
                                                   : `I2CM_ST_AW_NACK;
                            end else begin
                                si_code = !sda_now ? `I2CM_ST_D_ACK
                                                   : `I2CM_ST_D_NACK;
                            end
                        end
                    end
                end
            end
            I2CM_RESTART: begin
                // Release data, then clock, then start again
                if (phase_reg == 2'h2) begin
                    if (pins.scl && tick) begin
                        rstrt_next  = 1'b1;
                        sda_oe_next = 1'b1;
                        phase_next  = 2'h0;
                        state_next  = I2CM_START;
                    end
                end else if (tick) begin
                    phase_next = phase_reg + 2'h1;
                    if (phase_reg == 2'h0) begin
                        sda_oe_next = 1'b0;
                    end else begin
                        scl_oe_next = 1'b0;
                    end
                end
            end
            I2CM_STOP: begin
                // Data low, clock high, then data rises
                if (phase_reg == 2'h2) begin
                    if (pins.scl && tick) begin
                        phase_next = 2'h3;
                    end
                end else if (tick) begin
                    phase_next = phase_reg + 2'h1;
                    if (phase_reg == 2'h0) begin
                        sda_oe_next = 1'b1;
                    end else if (phase_reg == 2'h1) begin
                        scl_oe_next = 1'b0;
                    end else begin
                        sda_oe_next = 1'b0;
                        sto_clr     = 1'b1;
                        mrx_next    = 1'b0;
                        state_next  = flags_reg[`I2CM_STA_BIT] ? I2CM_WAIT_FREE
                                                                : I2CM_IDLE;
                    end
                end
            end
            default: begin
                state_next = I2CM_IDLE;
            end
        endcase

        // Disabled interface lets go of the bus at once
        if (!flags_reg[`I2CM_EN_BIT]) begin
            state_next  = I2CM_IDLE;
            scl_oe_next = 1'b0;
            sda_oe_next = 1'b0;
            lost_next   = 1'b0;
            mrx_next    = 1'b0;
            si_set      = 1'b0;
            sto_clr     = 1'b0;
        end

        // Status latched only as the flag is raised
        if (si_set) begin
            code_next = si_code;
        end

        // Set and clear ports; hardware set of the flag wins over a clear
        flags_next = flags_reg;
        if (flag_set_write) begin
            flags_next = flags_next | flag_set_port;
        end
        if (flag_clear_write) begin
            flags_next = flags_next & ~flag_clear_port;
        end
        if (si_set) begin
            flags_next[`I2CM_SI_BIT] = 1'b1;
        end
        if (sto_clr) begin
            flags_next[`I2CM_STO_BIT] = 1'b0;
        end
        flags_next[7] = 1'b0;
        flags_next[1] = 1'b0;
        flags_next[0] = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg  <= I2CM_IDLE;
            phase_reg  <= 2'h0;
            bit_reg    <= 4'h0;
            tx_reg     <= 9'h1FF;
            flags_reg  <= `I2CM_FLAGS_RST;
            code_reg   <= `I2CM_CODE_RST;
            data_reg   <= 8'h00;
            div_reg    <= 16'h0000;
            prev_reg   <= 2'h3;
            busy_reg   <= 1'b0;
            addr_reg   <= 1'b0;
            lost_reg   <= 1'b0;
            rstrt_reg  <= 1'b0;
            mrx_reg    <= 1'b0;
            scl_oe_reg <= 1'b0;
            sda_oe_reg <= 1'b0;
        end else begin
            state_reg  <= state_next;
            phase_reg  <= phase_next;
            bit_reg    <= bit_next;
            tx_reg     <= tx_next;
            flags_reg  <= flags_next;
            code_reg   <= code_next;
            data_reg   <= data_next;
            div_reg    <= div_next;
            prev_reg   <= prev_next;
            busy_reg   <= busy_next;
            addr_reg   <= addr_next;
            lost_reg   <= lost_next;
            rstrt_reg  <= rstrt_next;
            mrx_reg    <= mrx_next;
            scl_oe_reg <= scl_oe_next;
            sda_oe_reg <= sda_oe_next;
        end
    end

    // Flags, code and enables straight from flops; line outputs tied low, only ever pull low
    assign operation_flags     = flags_reg;
    assign shift_byte_register = data_reg;
    assign bus_condition_code  = code_reg;
    assign master_receive_mode = mrx_reg;
    assign scl_oe              = scl_oe_reg;
    assign sda_oe              = sda_oe_reg;
    assign scl_out             = 1'b0;
    assign sda_out             = 1'b0;

endmodule // i2cm_master_tx

`default_nettype wire

// [verification/i2cm_master_tx_checker.sv]
`timescale 1ns/1ps
`default_nettype none

module i2cm_master_tx_checker #(
    parameter int unsigned QTR_CYC = 4
) (
    // Clock and reset
    input wire logic       ref_clk,
    input wire logic       reset_n,
    // Control flag ports
    input wire logic       flag_set_write,
    input wire logic [7:0] flag_set_port,
    input wire logic       flag_clear_write,
    input wire logic [7:0] flag_clear_port,
    input wire logic [7:0] operation_flags,
    // Data and status
    input wire logic       data_write,
    input wire logic [7:0] data_in,
    input wire logic [7:0] shift_byte_register,
    input wire logic [7:0] bus_condition_code,
    input wire logic       master_receive_mode,
    // Bus lines
    input wire logic       scl_in,
    input wire logic       scl_out,
    input wire logic       scl_oe,
    input wire logic       sda_in,
    input wire logic       sda_out,
    input wire logic       sda_oe
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    // SDA pulled while SCL is not driven: a START of ours
    sequence start_seq;
        $rose(sda_oe) && !scl_oe;
    endsequence

    // Halt pending while the transfer runs
    sequence halt_run_seq;
        operation_flags[4] && !operation_flags[3] && operation_flags[6];
    endsequence

    ////////////////////////////////////////////////////////////////////////////
    code_low_zero_a: assert property (bus_condition_code[2:0] == 3'h0)
        else $error("status code low bits not zero");
    reserved_bits_a: assert property (operation_flags[7] == 1'b0 && operation_flags[1:0] == 2'h0)
        else $error("reserved flag bits set");
    set_port_a: assert property (flag_set_write && !flag_clear_write
        |=> (operation_flags & $past(flag_set_port) & 8'h7C) == ($past(flag_set_port) & 8'h7C))
        else $error("set port did not set flags");
    clear_port_a: assert property (flag_clear_write && !flag_set_write
        |=> (operation_flags & $past(flag_clear_port) & 8'h7C) == 8'h00)
        else $error("clear port did not clear flags");
    scl_hold_a: assert property (operation_flags[3] && $past(operation_flags[3]) |-> scl_oe)
        else $error("SCL not held low while flag set");
    code_stable_a: assert property (operation_flags[3] && $past(operation_flags[3])
        && $past(operation_flags[3], 2) |-> $stable(bus_condition_code))
        else $error("status code moved while flag set");
    start_free_a: assert property (start_seq |-> $past(scl_in) && $past(sda_in))
        else $error("START issued on a busy bus");
    start_flag_a: assert property (start_seq |-> ##[1:60] (operation_flags[3]
        && (bus_condition_code == 8'h08 || bus_condition_code == 8'h10)))
        else $error("no flag and start code after START");
    halt_clear_a: assert property (halt_run_seq |-> ##[1:200] !operation_flags[4])
        else $error("halt request not cleared");
    stop_quiet_a: assert property ($fell(operation_flags[4]) && !operation_flags[5]
        |-> !operation_flags[3] [*8])
        else $error("flag raised after plain STOP");
    rx_mode_a: assert property ($rose(master_receive_mode) |-> ##[0:3] (operation_flags[3]
        && (bus_condition_code == 8'h40 || bus_condition_code == 8'h48)))
        else $error("receive mode without read address code");
endmodule // i2cm_master_tx_checker

`default_nettype wire

// [verification/i2cm_slave_model.sv]
`timescale 1ns/1ps
`default_nettype none

module i2cm_slave_model (
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       reset_n,
    // Wire levels and test controls
    input  wire logic       scl,
    input  wire logic       sda,
    input  wire logic       ack_en,
    input  wire logic       steal,
    // Slave drive and capture
    output logic            sda_pull,
    output logic      [7:0] rx_byte
);
    logic       scl_q;
    logic       sda_q;
    logic       ack_pull;
    logic [3:0] bit_cnt;
    logic [3:0] next_cnt;

    // Steal pulls data bits low at once so a sent one loses arbitration
    assign sda_pull = ack_pull || (steal && bit_cnt < 4'h8);
    assign next_cnt = (bit_cnt == 4'h8) ? 4'h0 : bit_cnt + 4'h1;

    // START or STOP restarts the count; ninth bit answered on SCL fall
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            ack_pull <= 1'b0;
            bit_cnt <= 4'hF;
            rx_byte <= 8'h00;
        end else begin
            scl_q <= scl;
            sda_q <= sda;
            if (scl && scl_q && sda != sda_q) begin
                bit_cnt <= 4'hF;
                ack_pull <= 1'b0;
            end else if (scl && !scl_q && bit_cnt < 4'h8) begin
                rx_byte <= {rx_byte[6:0], sda};
            end else if (!scl && scl_q) begin
                bit_cnt <= next_cnt;
                ack_pull <= (next_cnt == 4'h8) && ack_en;
            end
        end
    end
endmodule // i2cm_slave_model

`default_nettype wire

// [verification/testbench.sv]
`timescale 1ns/1ps
`default_nettype none

bind i2cm_master_tx i2cm_master_tx_checker #(.QTR_CYC(QTR_CYC)) chk_i (.ref_clk, .reset_n,
    .flag_set_write, .flag_set_port, .flag_clear_write, .flag_clear_port, .operation_flags,
    .data_write, .data_in, .shift_byte_register, .bus_condition_code, .master_receive_mode,
    .scl_in, .scl_out, .scl_oe, .sda_in, .sda_out, .sda_oe);

module testbench;
    typedef struct packed {logic [7:0] data; logic ack; logic [7:0] code;} i2cm_row_t;
    // Stimulus and observed signals
    logic       ref_clk, reset_n, flag_set_write, flag_clear_write, data_write;
    logic [7:0] flag_set_port, flag_clear_port, data_in, operation_flags;
    logic [7:0] shift_byte_register, bus_condition_code, rx_byte;
    logic       master_receive_mode, scl_out, scl_oe, sda_out, sda_oe;
    logic       ack_en, steal, tb_sda_pull, sda_pull;
    int         fail_count, n_compared;
    // Open-drain wires with pull-ups
    wire        scl_w = !scl_oe;
    wire        sda_w = !(sda_oe || sda_pull || tb_sda_pull);
    // Data bytes, acknowledge given, code expected; NACK then a further byte
    i2cm_row_t  rows [4] = '{'{8'h5A, 1'b1, 8'h28}, '{8'hFF, 1'b0, 8'h30},
                             '{8'h00, 1'b1, 8'h28}, '{8'h81, 1'b0, 8'h30}};

    i2cm_master_tx #(.QTR_CYC(4)) i2cm_master_tx_i (.ref_clk, .reset_n, .flag_set_write,
        .flag_set_port, .flag_clear_write, .flag_clear_port, .operation_flags, .data_write,
        .data_in, .shift_byte_register, .bus_condition_code, .master_receive_mode,
        .scl_in(scl_w), .scl_out, .scl_oe, .sda_in(sda_w), .sda_out, .sda_oe);
    i2cm_slave_model i2cm_slave_model_i (.ref_clk, .reset_n, .scl(scl_w), .sda(sda_w),
        .ack_en, .steal, .sda_pull, .rx_byte);

    ////////////////////////////////////////////////////////////////////////////
    // 200 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask

    // One-cycle write: 0 set port, 1 clear port, 2 data
    task automatic op(input int k, input logic [7:0] v);
        @(negedge ref_clk);
        flag_set_write = (k == 0);
        flag_clear_write = (k == 1);
        data_write = (k == 2);
        flag_set_port = v;
        flag_clear_port = v;
        data_in = v;
        @(negedge ref_clk);
        flag_set_write = 1'b0;
        flag_clear_write = 1'b0;
        data_write = 1'b0;
    endtask

    // Bounded wait for the flag, then the latched code
    task automatic step(input logic [7:0] exp);
        int i;
        i = 0;
        while (operation_flags[3] !== 1'b1 && i < 3000) begin
            @(negedge ref_clk);
            i++;
        end
        check("flag", {7'h00, operation_flags[3]}, 8'h01);
        check("status code", bus_condition_code, exp);
    endtask

    task automatic close_out;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // Watchdog well beyond the expected run
    initial begin
        #300000;
        fail_count++;
        close_out();
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {reset_n, flag_set_write, flag_clear_write, data_write, steal, tb_sda_pull} = 6'h00;
        {flag_set_port, flag_clear_port, data_in} = 24'h0000_00;
        ack_en = 1'b1;
        fail_count = 0;
        n_compared = 0;
        repeat (8) @(negedge ref_clk);
        reset_n = 1'b1;
        check("code", bus_condition_code, 8'hF8);
        check("flags", operation_flags, 8'h00);
        $display("test reset done");
        op(0, 8'h44);
        check("flags", operation_flags, 8'h44);
        op(0, 8'h20);
        step(8'h08);
        op(2, 8'hA4);
        check("data", shift_byte_register, 8'hA4);
        repeat (40) @(negedge ref_clk);
        check("held code", bus_condition_code, 8'h08);
        op(1, 8'h28);
        step(8'h18);
        check("address", rx_byte, 8'hA4);
        $display("test address done");
        // Data bytes with acknowledge and refusal
        for (int r = 0; r < 4; r++) begin
            ack_en = rows[r].ack;
            op(2, rows[r].data);
            op(1, 8'h08);
            step(rows[r].code);
            check("wire byte", rx_byte, rows[r].data);
        end
        $display("test data done");
        // Repeated START, read address, then write address refused
        op(0, 8'h20);
        op(1, 8'h08);
        step(8'h10);
        ack_en = 1'b1;
        op(2, 8'hA5);
        op(1, 8'h28);
        step(8'h40);
        check("receive mode", {7'h00, master_receive_mode}, 8'h01);
        op(0, 8'h20);
        op(1, 8'h08);
        step(8'h10);
        ack_en = 1'b0;
        op(2, 8'hA4);
        op(1, 8'h28);
        step(8'h20);
        $display("test restart done");
        // STOP followed by START, then plain STOP
        op(0, 8'h30);
        op(1, 8'h08);
        step(8'h08);
        check("halt", operation_flags & 8'h10, 8'h00);
        ack_en = 1'b1;
        op(2, 8'hA4);
        op(1, 8'h28);
        step(8'h18);
        op(0, 8'h10);
        op(1, 8'h08);
        repeat (200) @(negedge ref_clk);
        check("flags", operation_flags, 8'h44);
        check("code kept", bus_condition_code, 8'h18);
        check("lines", {4'h0, scl_out, sda_out, scl_oe, sda_oe}, 8'h00);
        $display("test stop done");
        // Arbitration lost, restart only once the bus is free
        op(0, 8'h20);
        step(8'h08);
        steal = 1'b1;
        op(2, 8'hA4);
        op(1, 8'h28);
        step(8'h38);
        steal = 1'b0;
        tb_sda_pull = 1'b1;
        op(0, 8'h20);
        op(1, 8'h08);
        repeat (100) @(negedge ref_clk);
        check("waiting", {7'h00, sda_oe}, 8'h00);
        tb_sda_pull = 1'b0;
        step(8'h08);
        steal = 1'b1;
        op(2, 8'hA4);
        op(1, 8'h28);
        step(8'h38);
        steal = 1'b0;
        op(1, 8'h08);
        repeat (100) @(negedge ref_clk);
        check("released", {6'h00, scl_oe, sda_oe}, 8'h00);
        check("flags", operation_flags, 8'h44);
        $display("test arbitration done");
        close_out();
    end
endmodule // testbench

`default_nettype wire
